// File: inc/acl_pkg.sv
// Constants and types for the AC-link frame controller.
// Assumes a single APB slave with 8-bit byte addresses and 32-bit data.
package acl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE  = 8'h00;
    localparam logic [7:0] OFS_CMD   = 8'h04;
    localparam logic [7:0] OFS_CSTAT = 8'h08;
    localparam logic [7:0] OFS_SR    = 8'h0c;
    localparam logic [7:0] OFS_IER   = 8'h10;
    localparam logic [7:0] OFS_IDR   = 8'h14;
    localparam logic [7:0] OFS_IMR   = 8'h18;
    localparam logic [7:0] OFS_ICA   = 8'h1c;
    localparam logic [7:0] OFS_OCA   = 8'h20;
    localparam logic [7:0] OFS_CAMR  = 8'h24;
    localparam logic [7:0] OFS_CBMR  = 8'h28;
    localparam logic [7:0] OFS_CATHR = 8'h2c;
    localparam logic [7:0] OFS_CARHR = 8'h30;
    localparam logic [7:0] OFS_CBTHR = 8'h34;
    localparam logic [7:0] OFS_CBRHR = 8'h38;
    // Field positions
    localparam int MODE_EN_BIT  = 0;
    localparam int MODE_VSR_BIT = 1;
    localparam int CMD_RD_BIT   = 23;
    localparam int CHM_CEN_BIT  = 4;
    localparam int SR_CMDRDY    = 8;
    localparam int SR_STATRDY   = 9;
    localparam int SR_CH_STRIDE = 4;
    // Values after reset
    localparam logic [9:0]  IMR_RST  = 10'h000;
    localparam logic [19:0] MAP_RST  = 20'h00000;
    localparam logic [1:0]  SIZE_RST = 2'h0;
    // Frame geometry
    localparam logic [3:0] SLOT_LAST = 4'hc;
    localparam logic [4:0] TAG_MSB   = 5'h0f;
    localparam logic [4:0] SLOT_MSB  = 5'h13;
    localparam logic [4:0] SLOT_W    = 5'h14;
    localparam logic [8:0] FRAME_BITS = 9'h100;
    // Codec identifier placed in the outgoing tag (primary codec)
    localparam logic [1:0] CODEC_ID = 2'h0;
    // Sample size codes
    localparam logic [1:0] SZ_20 = 2'h0;
    localparam logic [1:0] SZ_18 = 2'h1;
    localparam logic [1:0] SZ_16 = 2'h2;
    localparam logic [1:0] SZ_10 = 2'h3;
    // Slot assignment codes
    localparam logic [1:0] CHAN_NONE = 2'h0;
    localparam logic [1:0] CHAN_A    = 2'h1;
    localparam logic [1:0] CHAN_B    = 2'h2;

    typedef enum logic [1:0] {
        LNK_IDLE = 2'b01,
        LNK_RUN  = 2'b10
    } acl_link_type;
endpackage

// File: design/acl_ctrl.sv
// AC-link frame controller: APB register file, frame builder and parser.
// Assumes pclk runs well above the codec bit clock, which is sampled as data.
`timescale 1ns/1ns

// Summary of operation
// - Channel samples may be 10, 16, 18 or 20 bits wide.
// - Frame sync is driven by the controller, once per 48 kHz frame.
// - Outgoing frames leave on the serial transmit line.
// - Incoming frames arrive on the serial receive line.
// - No codec reset output here; a general-purpose pin provides it.
// - Everything crossing from the bit clock side is resynchronised.
// - Interrupt output is high while any unmasked source is pending.
// - Source found from mask AND global status, then channel status.
// - Channel A offers DMA requests for streaming without polling.
// - Twelve 20-bit data slots follow the tag in each direction.
// - Out slot 0 tag, 1 command address, 2 command data, 3-12 data.
// - The 16-bit tag slot always opens every frame.
// - First tag bit flags the whole frame valid.
// - Next twelve tag bits flag each slot valid; sampled on receive.
// - Last two tag bits carry the codec identifier.
// - Outgoing tag built from pending requests and slot requests in VSR.
// - Command slot: bit 19 read flag, bits 18:12 index, 11:0 zero.
// - Codec space is up to sixty-four 16-bit registers, even indices.
// - Data slot carries value in bits 19:4, bits 3:0 zero.
// - Read commands send an all-zero command data slot.
// - Slots 1 and 2 belong only to the codec channel.
// - Slots 3-12 map to channel A, B or none; 0-2 never.
// - Link data goes most significant bit first.
module acl_ctrl (
    // System clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // AC-link pins
    input  wire logic        codec_bit_clock,
    input  wire logic        serial_receive_line,
    output logic             frame_sync_out,
    output logic             serial_transmit_line,
    // Interrupt and DMA requests
    output logic             irq,
    output logic             dma_tx_req,
    output logic             dma_rx_req
);
    import acl_pkg::*;

    function automatic logic [1:0] acl_chan(input logic [19:0] map, input int s);
        acl_chan = map[2*(s-3) +: 2];
    endfunction

    function automatic logic [4:0] acl_width(input logic [1:0] sz);
        case (sz)
            SZ_18:   acl_width = 5'd18;
            SZ_16:   acl_width = 5'd16;
            SZ_10:   acl_width = 5'd10;
            default: acl_width = 5'd20;
        endcase
    endfunction

    // Synchronisers
    logic [2:0]   bck;
    logic [1:0]   rxs;
    logic         brise, bfall, run;
    // Register state
    logic         en, vsr, next_en, next_vsr;
    logic [9:0]   imr, next_imr;
    logic [19:0]  ica, oca, next_ica, next_oca;
    logic [1:0]   size [2];
    logic [1:0]   next_size [2];
    logic         cen [2];
    logic         next_cen [2];
    logic [19:0]  thr [2];
    logic [19:0]  next_thr [2];
    logic [19:0]  rhr [2];
    logic [19:0]  next_rhr [2];
    logic [19:0]  shadow [2];
    logic [19:0]  next_shadow [2];
    logic [3:0]   tx_sel [2];
    logic [3:0]   next_tx_sel [2];
    logic         thr_full [2];
    logic         next_thr_full [2];
    logic         rxrdy [2];
    logic         next_rxrdy [2];
    logic         ovr [2];
    logic         next_ovr [2];
    logic         cmd_pend, cmd_fly, cmd_rd, next_cmd_pend, next_cmd_fly, next_cmd_rd;
    logic [6:0]   cmd_idx, stat_idx, next_cmd_idx, next_stat_idx;
    logic [15:0]  cmd_data, stat_data, next_cmd_data, next_stat_data;
    logic         stat_rdy, next_stat_rdy;
    logic [9:0]   req_n, next_req_n;
    // Link state
    acl_link_type lnk, next_lnk;
    logic [3:0]   slot, rx_slot, next_slot, next_rx_slot;
    logic [4:0]   bitl, rx_bit, next_bitl, next_rx_bit;
    logic [15:0]  tag, rx_tag, next_tag, next_rx_tag;
    logic [19:0]  rx_sh, next_rx_sh;
    // Output next values and scratch
    logic [31:0]  next_prdata, rd;
    logic         next_pready, next_pslverr, next_fs, next_tx, next_irq;
    logic         next_dma_tx, next_dma_rx, hit, setup, acc, found;
    logic [9:0]   sr;
    logic [19:0]  word, w;
    logic [3:0]   sel;

    // Two flops before any logic looks at the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bck <= 3'h0;
            rxs <= 2'h0;
        end else begin
            bck <= {bck[1:0], codec_bit_clock};
            rxs <= {rxs[0], serial_receive_line};
        end
    end

    assign brise = bck[1] & ~bck[2];
    assign bfall = ~bck[1] & bck[2];
    assign run   = (lnk == LNK_RUN);
    assign sr    = {stat_rdy, ~(cmd_pend | cmd_fly), 1'b0, ovr[1], rxrdy[1], ~thr_full[1],
                    1'b0, ovr[0], rxrdy[0], ~thr_full[0]};

    always_comb begin
        next_en = en;  next_vsr = vsr;  next_imr = imr;
        next_ica = ica;  next_oca = oca;
        next_size = size;  next_cen = cen;  next_thr = thr;  next_rhr = rhr;
        next_shadow = shadow;  next_tx_sel = tx_sel;  next_thr_full = thr_full;
        next_rxrdy = rxrdy;  next_ovr = ovr;
        next_cmd_pend = cmd_pend;  next_cmd_fly = cmd_fly;  next_cmd_rd = cmd_rd;
        next_cmd_idx = cmd_idx;  next_cmd_data = cmd_data;
        next_stat_idx = stat_idx;  next_stat_data = stat_data;  next_stat_rdy = stat_rdy;
        next_req_n = req_n;  next_lnk = lnk;  next_slot = slot;  next_bitl = bitl;
        next_rx_slot = rx_slot;  next_rx_bit = rx_bit;  next_tag = tag;
        next_rx_tag = rx_tag;  next_rx_sh = rx_sh;
        next_prdata = prdata;  next_pslverr = pslverr;
        next_fs = frame_sync_out;  next_tx = serial_transmit_line;
        w = 20'h0;  sel = 4'h0;  found = 1'b0;

        // APB: answer in the first access cycle, data latched at setup
        setup = psel & ~penable;
        acc   = psel & penable & pready;
        next_pready = setup;
        hit = 1'b1;
        case (paddr)
            OFS_MODE:  rd = {30'h0, vsr, en};
            OFS_CMD:   rd = {8'h0, cmd_rd, cmd_idx, cmd_data};
            OFS_CSTAT: rd = {9'h0, stat_idx, stat_data};
            OFS_SR:    rd = {22'h0, sr};
            OFS_IER:   rd = 32'h0;
            OFS_IDR:   rd = 32'h0;
            OFS_IMR:   rd = {22'h0, imr};
            OFS_ICA:   rd = {12'h0, ica};
            OFS_OCA:   rd = {12'h0, oca};
            OFS_CAMR:  rd = {27'h0, cen[0], 2'h0, size[0]};
            OFS_CBMR:  rd = {27'h0, cen[1], 2'h0, size[1]};
            OFS_CATHR: rd = {12'h0, thr[0]};
            OFS_CARHR: rd = {12'h0, rhr[0]};
            OFS_CBTHR: rd = {12'h0, thr[1]};
            OFS_CBRHR: rd = {12'h0, rhr[1]};
            default: begin
                rd  = 32'h0;
                hit = 1'b0;
            end
        endcase
        if (setup) begin
            next_prdata  = rd;
            next_pslverr = ~hit;
        end
        if (acc && pwrite) begin
            case (paddr)
                OFS_MODE: begin
                    next_en  = pwdata[MODE_EN_BIT];
                    next_vsr = pwdata[MODE_VSR_BIT];
                end
                OFS_CMD: begin
                    // A command written while one is queued or on the link is dropped
                    if (!(cmd_pend || cmd_fly)) begin
                        next_cmd_pend = 1'b1;
                        next_cmd_rd   = pwdata[CMD_RD_BIT];
                        next_cmd_idx  = pwdata[22:16];
                        next_cmd_data = pwdata[15:0];
                    end
                end
                OFS_IER:   next_imr = imr | pwdata[9:0];
                OFS_IDR:   next_imr = imr & ~pwdata[9:0];
                OFS_ICA:   next_ica = pwdata[19:0];
                OFS_OCA:   next_oca = pwdata[19:0];
                OFS_CAMR: begin
                    next_size[0] = pwdata[1:0];
                    next_cen[0]  = pwdata[CHM_CEN_BIT];
                end
                OFS_CBMR: begin
                    next_size[1] = pwdata[1:0];
                    next_cen[1]  = pwdata[CHM_CEN_BIT];
                end
                OFS_CATHR: begin
                    next_thr[0]      = pwdata[19:0];
                    next_thr_full[0] = 1'b1;
                end
                OFS_CBTHR: begin
                    next_thr[1]      = pwdata[19:0];
                    next_thr_full[1] = 1'b1;
                end
                default: ;
            endcase
        end
        if (acc && !pwrite) begin
            // Reads that acknowledge flags; hardware sets below take priority
            case (paddr)
                OFS_CSTAT: next_stat_rdy = 1'b0;
                OFS_SR: begin
                    next_ovr[0] = 1'b0;
                    next_ovr[1] = 1'b0;
                end
                OFS_CARHR: next_rxrdy[0] = 1'b0;
                OFS_CBRHR: next_rxrdy[1] = 1'b0;
                default: ;
            endcase
        end

        // Word launched in the current slot
        case (slot)
            4'h0:    word = {4'h0, tag};
            4'h1:    word = cmd_fly ? {cmd_rd, cmd_idx, 12'h0} : 20'h0;
            4'h2:    word = (cmd_fly && !cmd_rd) ? {cmd_data, 4'h0} : 20'h0;
            default: begin
                word = 20'h0;
                for (int c = 0; c < 2; c++) begin
                    if (tag[15-int'(slot)] && tx_sel[c] == slot) begin
                        word = shadow[c];
                    end
                end
            end
        endcase

        if (!en) begin
            // Disabling abandons the frame and parks the link low
            next_lnk    = LNK_IDLE;
            next_slot   = SLOT_LAST;
            next_bitl   = 5'h0;
            next_fs     = 1'b0;
            next_tx     = 1'b0;
            next_rx_bit = 5'h1;
        end else begin
            next_lnk = LNK_RUN;
        end

        if (run && en && brise) begin
            next_tx      = word[bitl];
            next_fs      = (slot == 4'h0);
            next_rx_slot = slot;
            next_rx_bit  = bitl;
            if (bitl != 5'h0) begin
                next_bitl = bitl - 5'h1;
            end else if (slot != SLOT_LAST) begin
                next_slot = slot + 4'h1;
                next_bitl = SLOT_MSB;
            end else begin
                // Frame boundary: freeze everything the next frame will carry
                next_slot     = 4'h0;
                next_bitl     = TAG_MSB;
                next_cmd_fly  = cmd_pend;
                next_cmd_pend = 1'b0;
                next_tag      = {cmd_pend, cmd_pend, cmd_pend & ~cmd_rd, 10'h0, 1'b0, CODEC_ID};
                for (int c = 0; c < 2; c++) begin
                    found = 1'b0;
                    sel   = 4'h0;
                    for (int s = 12; s >= 3; s--) begin
                        if (acl_chan(oca, s) == 2'(c + 1) && !(vsr && req_n[s-3])) begin
                            found = 1'b1;
                            sel   = 4'(s);
                        end
                    end
                    if (found && cen[c] && thr_full[c]) begin
                        next_tx_sel[c]   = sel;
                        next_tag[15]     = 1'b1;
                        next_tag[15-sel] = 1'b1;
                        next_shadow[c]   = thr[c] << (SLOT_W - acl_width(size[c]));
                        next_thr_full[c] = 1'b0;
                    end
                end
            end
        end

        if (run && en && bfall) begin
            w          = {rx_sh[18:0], rxs[1]};
            next_rx_sh = w;
            if (rx_bit == 5'h0) begin
                case (rx_slot)
                    4'h0: next_rx_tag = w[15:0];
                    4'h1: begin
                        if (rx_tag[15] && rx_tag[14]) begin
                            next_stat_idx = w[18:12];
                            for (int s = 3; s <= 12; s++) begin
                                next_req_n[s-3] = w[14-s];
                            end
                        end
                    end
                    4'h2: begin
                        if (rx_tag[15] && rx_tag[13]) begin
                            next_stat_data = w[19:4];
                            next_stat_rdy  = 1'b1;
                        end
                    end
                    default: begin
                        for (int c = 0; c < 2; c++) begin
                            if (rx_tag[15] && rx_tag[15-int'(rx_slot)] && cen[c]
                                && acl_chan(ica, int'(rx_slot)) == 2'(c + 1)) begin
                                next_rhr[c]   = w >> (SLOT_W - acl_width(size[c]));
                                next_rxrdy[c] = 1'b1;
                                next_ovr[c]   = ovr[c] | rxrdy[c];
                            end
                        end
                    end
                endcase
            end
        end

        next_irq    = |(sr & imr);
        next_dma_tx = cen[0] & ~thr_full[0];
        next_dma_rx = rxrdy[0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en <= 1'b0;  vsr <= 1'b0;  imr <= IMR_RST;  ica <= MAP_RST;  oca <= MAP_RST;
            for (int c = 0; c < 2; c++) begin
                size[c] <= SIZE_RST;  cen[c] <= 1'b0;  thr[c] <= 20'h0;  rhr[c] <= 20'h0;
                shadow[c] <= 20'h0;  tx_sel[c] <= 4'h0;  thr_full[c] <= 1'b0;
                rxrdy[c] <= 1'b0;  ovr[c] <= 1'b0;
            end
            cmd_pend <= 1'b0;  cmd_fly <= 1'b0;  cmd_rd <= 1'b0;  cmd_idx <= 7'h0;
            cmd_data <= 16'h0;  stat_idx <= 7'h0;  stat_data <= 16'h0;  stat_rdy <= 1'b0;
            req_n <= 10'h0;  lnk <= LNK_IDLE;  slot <= SLOT_LAST;  bitl <= 5'h0;
            rx_slot <= SLOT_LAST;  rx_bit <= 5'h1;  tag <= 16'h0;  rx_tag <= 16'h0;
            rx_sh <= 20'h0;  prdata <= 32'h0;  pready <= 1'b0;  pslverr <= 1'b0;
            frame_sync_out <= 1'b0;  serial_transmit_line <= 1'b0;  irq <= 1'b0;
            dma_tx_req <= 1'b0;  dma_rx_req <= 1'b0;
        end else begin
            en <= next_en;  vsr <= next_vsr;  imr <= next_imr;  ica <= next_ica;  oca <= next_oca;
            size <= next_size;  cen <= next_cen;  thr <= next_thr;  rhr <= next_rhr;
            shadow <= next_shadow;  tx_sel <= next_tx_sel;  thr_full <= next_thr_full;
            rxrdy <= next_rxrdy;  ovr <= next_ovr;
            cmd_pend <= next_cmd_pend;  cmd_fly <= next_cmd_fly;  cmd_rd <= next_cmd_rd;
            cmd_idx <= next_cmd_idx;  cmd_data <= next_cmd_data;  stat_idx <= next_stat_idx;
            stat_data <= next_stat_data;  stat_rdy <= next_stat_rdy;  req_n <= next_req_n;
            lnk <= next_lnk;  slot <= next_slot;  bitl <= next_bitl;  rx_slot <= next_rx_slot;
            rx_bit <= next_rx_bit;  tag <= next_tag;  rx_tag <= next_rx_tag;  rx_sh <= next_rx_sh;
            prdata <= next_prdata;  pready <= next_pready;  pslverr <= next_pslverr;
            frame_sync_out <= next_fs;  serial_transmit_line <= next_tx;  irq <= next_irq;
            dma_tx_req <= next_dma_tx;  dma_rx_req <= next_dma_rx;
        end
    end

    // Checks
    logic [8:0] fcount;
    logic       fseen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcount <= 9'h0;
            fseen  <= 1'b0;
        end else if (!en) begin
            fcount <= 9'h0;
            fseen  <= 1'b0;
        end else if (run && brise) begin
            fcount <= (slot == 4'h0 && bitl == TAG_MSB) ? 9'h1 : fcount + 9'h1;
            fseen  <= fseen | (slot == 4'h0 && bitl == TAG_MSB);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_launch(logic [3:0] sl);
        run && en && brise && slot == sl;
    endsequence

    property p_frame_len;
        s_launch(4'h0) and (bitl == TAG_MSB) and fseen |-> fcount == FRAME_BITS;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length not 256 bits");

    property p_sync;
        s_launch(4'h0) |=> frame_sync_out ##0 (frame_sync_out [*1]);
    endproperty
    a_sync: assert property (p_sync) else $error("sync low during tag slot");

    property p_sync_off;
        run && en && brise && slot != 4'h0 |=> !frame_sync_out;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync high outside tag slot");

    property p_rdflag;
        s_launch(4'h1) and (bitl == SLOT_MSB) |=> serial_transmit_line == $past(cmd_fly && cmd_rd);
    endproperty
    a_rdflag: assert property (p_rdflag) else $error("command read flag wrong");

    property p_rdzero;
        s_launch(4'h2) and cmd_fly and cmd_rd |=> !serial_transmit_line;
    endproperty
    a_rdzero: assert property (p_rdzero) else $error("read command data slot not zero");

    property p_nibble;
        s_launch(4'h2) and (bitl < 5'h4) |=> !serial_transmit_line;
    endproperty
    a_nibble: assert property (p_nibble) else $error("command data low bits not zero");

    property p_codec_id;
        s_launch(4'h0) and (bitl < 5'h2) |=> serial_transmit_line == $past(CODEC_ID[bitl[0]]);
    endproperty
    a_codec_id: assert property (p_codec_id) else $error("codec id bits wrong");

    property p_global;
        s_launch(4'h0) and (bitl == TAG_MSB) |=> serial_transmit_line == $past(|tag[14:3]);
    endproperty
    a_global: assert property (p_global) else $error("frame valid bit disagrees with slot bits");

    property p_irq;
        (|(sr & imr)) ##1 (|(sr & imr)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked source did not raise irq");

    property p_txedge;
        !$stable(serial_transmit_line) && $past(en) |-> $past(brise);
    endproperty
    a_txedge: assert property (p_txedge) else $error("transmit changed away from a bit clock rise");
endmodule

// File: dv/acl_codec_model.sv
// Behavioural codec at the far end of the AC-link: makes the bit clock, captures frames.
// Assumes the controller launches sync and data off the bit clock rise.
`timescale 1ns/1ns
module acl_codec_model (
    // Link pins
    output logic         codec_bit_clock,
    output logic         serial_receive_line,
    input  wire logic    frame_sync_out,
    input  wire logic    serial_transmit_line,
    // Last whole frame seen
    output logic [255:0] last_frame,
    output logic [255:0] last_sync,
    output int           frame_cnt
);
    logic [255:0] data_sh;
    logic [255:0] sync_sh;
    int           bit_cnt;
    logic         sync_q;
    // Free running, well below pclk so the crossing works
    initial begin
        codec_bit_clock = 1'b0;
        forever #16 codec_bit_clock = ~codec_bit_clock;
    end
    // Incoming frames all carry a cleared valid flag
    initial serial_receive_line = 1'b0;
    initial {bit_cnt, sync_q, frame_cnt, data_sh, sync_sh} = '0;
    // Sampled on the fall; a frame starts at the bit where sync first shows
    always @(negedge codec_bit_clock) begin
        data_sh = {data_sh[254:0], serial_transmit_line};
        sync_sh = {sync_sh[254:0], frame_sync_out};
        if (frame_sync_out && !sync_q) bit_cnt = 1;
        else if (bit_cnt != 0) bit_cnt = bit_cnt + 1;
        sync_q = frame_sync_out;
        if (bit_cnt == 256) begin
            last_frame = data_sh;
            last_sync  = sync_sh;
            frame_cnt  = frame_cnt + 1;
            bit_cnt    = 0;
        end
    end
endmodule

// File: dv/acl_ctrl_tb.sv
// Self-checking bench: APB master tasks and AC-link command frame checks.
// Assumes the codec model captures every outgoing frame.
`timescale 1ns/1ns
module acl_ctrl_tb;
    import acl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ck, rx, fs, tx, irq, dtx, drx;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [255:0] fr, sy, lf;
    int error_cnt, compares, fcnt;
    acl_ctrl acl_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .codec_bit_clock(ck), .serial_receive_line(rx), .frame_sync_out(fs), .serial_transmit_line(tx),
        .irq(irq), .dma_tx_req(dtx), .dma_rx_req(drx));
    acl_codec_model acl_codec_model_inst (.codec_bit_clock(ck), .serial_receive_line(rx),
        .frame_sync_out(fs), .serial_transmit_line(tx), .last_frame(lf), .last_sync(sy), .frame_cnt(fcnt));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        chk(pslverr, (a > OFS_CBRHR) ? 1 : 0);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Sends one command once the slot is free, returns the frame carrying it
    task send_cmd(input logic [31:0] c);
        rd = 0;
        for (int i = 0; i < 3000 && !rd[SR_CMDRDY]; i++) apb(1'b0, OFS_SR, 0);
        apb(1'b1, OFS_CMD, c);
        fr = 0;
        // A private copy, so the previous command's frame cannot end the wait
        for (int i = 0; i < 4 && !fr[254]; i++) begin
            @(fcnt);
            fr = lf;
        end
    endtask
    task t_bus;
        apb(1'b1, 8'hfc, 32'hffff_ffff);
        apb(1'b0, 8'hfc, 0);
        $display("test bus done");
    endtask
    task t_write_cmd;
        apb(1'b1, OFS_MODE, 32'h1);
        send_cmd({8'h00, 8'h02, 16'h1234});
        chk(fr[255:240], 16'he000);
        chk(fr[239:220], {1'b0, 7'h02, 12'h000});
        chk(fr[219:200], {16'h1234, 4'h0});
        chk(fr[199:0] == 0, 1);
        chk(sy == {16'hffff, 240'h0}, 1);
        $display("test write command done");
    endtask
    task t_read_cmd;
        send_cmd({8'h00, 8'hfe, 16'hffff});
        chk(fr[255:254], 2'h3);
        chk(fr[241:240], 2'h0);
        chk(fr[239:220], {1'b1, 7'h7e, 12'h000});
        chk(fr[219:200], 0);
        $display("test read command done");
    endtask
    task t_irq_dma;
        apb(1'b1, OFS_IER, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1);
        apb(1'b0, OFS_IMR, 0);
        chk(rd, 32'h1);
        apb(1'b1, OFS_IDR, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 0);
        apb(1'b1, OFS_CAMR, 32'h10);
        repeat (2) @(posedge pclk);
        chk(dtx, 1);
        apb(1'b1, OFS_CATHR, 32'h5);
        repeat (2) @(posedge pclk);
        chk(dtx, 0);
        chk(drx, 0);
        $display("test irq dma done");
    endtask
    task end_of_test;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, error_cnt, compares} = '0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_bus;
        t_write_cmd;
        t_read_cmd;
        t_irq_dma;
        end_of_test;
    end
    initial begin
        #300000;
        error_cnt++;
        end_of_test;
    end
endmodule
